// *** src/core_rail_and_fet_ctrl_regs.sv ***
// Register bank for the second core rail and the external-FET rail.
// Assumes each access port delivers one-cycle byte write/read strobes.
//
// Overview of operation
// - Gain field bits 7:6 give x1 for 00/01, x2 for 10, x3 for 11.
// - Bit 5 picks a 1.0 A limit when clear and above 1.5 A when set.
// - Setpoint changes move the output in 12.5 mV steps paced by a 3-bit field resetting to 1.
// - Core rail state 00/10 is off, 01 is high power, 11 is low power.
// - Command bit 7 of the operating register selects operating or scaling code.
// - Codes 3 to 75 give (code x 12.5 mV + 0.5625 V) times gain.
// - Codes of 75 and above saturate at the code-75 target.
// - Code 0 turns the rail off and codes 1 to 3 give the 0.6 V minimum.
// - Both setpoint registers are reachable from the port chosen by the port bit.
// - FET rail state 00/10 is off, 01/11 is on, bits 7:2 reserved.
// - Every register resets on the turn-off reset event and on the synchronised RESET_N_I.
`timescale 1ns/1ps
module core_rail_and_fet_ctrl_regs #(
   parameter int UNIT_CYC = core_rail_pkg::STEP_UNIT_CYC
) (
   input  wire logic       MCLK_I,
   input  wire logic       RESET_N_I,
   input  wire logic       TURNOFF_RESET_I,
   input  wire logic       SCALING_PORT_CHOICE_I,
   input  wire logic       SLEW_BYPASS_I,
   input  wire logic [7:0] CTL_ADDR_I,
   input  wire logic [7:0] CTL_WDATA_I,
   input  wire logic       CTL_WR_I,
   input  wire logic       CTL_RD_I,
   output logic      [7:0] CTL_RDATA_O,
   input  wire logic [7:0] SCL_ADDR_I,
   input  wire logic [7:0] SCL_WDATA_I,
   input  wire logic       SCL_WR_I,
   input  wire logic       SCL_RD_I,
   output logic      [7:0] SCL_RDATA_O,
   output logic      [1:0] OUTPUT_GAIN_CHOICE_O,
   output logic            LOAD_CURRENT_LIMIT_HIGH_O,
   output logic            CORE_RAIL_ON_O,
   output logic            CORE_RAIL_LOW_POWER_O,
   output logic      [9:0] CORE_RAIL_TARGET_O,
   output logic      [9:0] CORE_RAIL_LEVEL_O,
   output logic            CORE_RAIL_SLEWING_O,
   output logic            EXTERNAL_FET_RAIL_ON_O
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] oper;
      logic [7:0] scale;
      logic [7:0] fet;
      logic [7:0] ctl_rd;
      logic [7:0] scl_rd;
      logic [1:0] gain;
      logic       ilim;
      logic       on;
      logic       lowp;
      logic [9:0] target;
      logic [9:0] level;
      logic       slewing;
      logic       fet_on;
   } regs_t;
   regs_t r_r;
   regs_t r_nxt;
   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic [9:0] slew_level;
   logic       slew_busy;
   logic [6:0] code;
   logic [9:0] units;
   logic [1:0] gain_mult;

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] read_reg(input regs_t r, input logic [7:0] a,
                                           input logic setp_ok);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         core_rail_pkg::CTRL_OFFSET:  d = r.ctrl;
         core_rail_pkg::OPER_OFFSET:  d = setp_ok ? r.oper : 8'h00;
         core_rail_pkg::SCALE_OFFSET: d = setp_ok ? (r.scale & core_rail_pkg::SCALE_WMASK) : 8'h00;
         core_rail_pkg::FET_OFFSET:   d = r.fet & core_rail_pkg::FET_WMASK;
         default:                     d = 8'h00;
      endcase
      return d;
   endfunction

   always_comb
   begin
      r_nxt = r_r;
      // Scaling port owns setpoints when its choice bit is set, control port otherwise
      if (CTL_WR_I)
      begin
         case (CTL_ADDR_I)
            core_rail_pkg::CTRL_OFFSET:  r_nxt.ctrl = CTL_WDATA_I;
            core_rail_pkg::OPER_OFFSET:  if (!SCALING_PORT_CHOICE_I) r_nxt.oper = CTL_WDATA_I;
            core_rail_pkg::SCALE_OFFSET:
               if (!SCALING_PORT_CHOICE_I) r_nxt.scale = CTL_WDATA_I & core_rail_pkg::SCALE_WMASK;
            core_rail_pkg::FET_OFFSET:   r_nxt.fet = CTL_WDATA_I & core_rail_pkg::FET_WMASK;
            default:                     r_nxt.fet = r_nxt.fet;
         endcase
      end
      if (SCL_WR_I && SCALING_PORT_CHOICE_I)
      begin
         case (SCL_ADDR_I)
            core_rail_pkg::OPER_OFFSET:  r_nxt.oper = SCL_WDATA_I;
            core_rail_pkg::SCALE_OFFSET: r_nxt.scale = SCL_WDATA_I & core_rail_pkg::SCALE_WMASK;
            default:                     r_nxt.oper = r_nxt.oper;
         endcase
      end
      if (CTL_RD_I)
         r_nxt.ctl_rd = read_reg(r_r, CTL_ADDR_I, !SCALING_PORT_CHOICE_I);
      if (SCL_RD_I)
         r_nxt.scl_rd = read_reg(r_r, SCL_ADDR_I, SCALING_PORT_CHOICE_I);

      // Applied setpoint from command bit
      code = r_r.oper[core_rail_pkg::CMD_BIT] ? r_r.scale[6:0] : r_r.oper[6:0];
      if (code == core_rail_pkg::CODE_OFF)
         units = 10'h000;
      else if (code <= core_rail_pkg::CODE_MIN)
         units = {3'h0, core_rail_pkg::CODE_MIN} + core_rail_pkg::BASE_STEPS;
      else if (code >= core_rail_pkg::CODE_MAX)
         units = {3'h0, core_rail_pkg::CODE_MAX} + core_rail_pkg::BASE_STEPS;
      else
         units = {3'h0, code} + core_rail_pkg::BASE_STEPS;
      case (r_r.ctrl[core_rail_pkg::GAIN_HI:core_rail_pkg::GAIN_LO])
         2'h2:    gain_mult = 2'h2;
         2'h3:    gain_mult = 2'h3;
         default: gain_mult = 2'h1;
      endcase
      r_nxt.target = 10'(units * gain_mult);
      r_nxt.gain = gain_mult;
      r_nxt.ilim = r_r.ctrl[core_rail_pkg::ILIM_BIT];
      r_nxt.on = r_r.ctrl[core_rail_pkg::STATE_LO] && (units != 10'h000);
      r_nxt.lowp = r_r.ctrl[core_rail_pkg::STATE_HI] && r_r.ctrl[core_rail_pkg::STATE_LO];
      r_nxt.fet_on = r_r.fet[core_rail_pkg::STATE_LO];
      r_nxt.level = slew_level;
      r_nxt.slewing = slew_busy;

      // Turn-off event overrides everything
      if (TURNOFF_RESET_I)
      begin
         r_nxt = '0;
         r_nxt.ctrl = core_rail_pkg::CTRL_RESET;
         r_nxt.oper = core_rail_pkg::OPER_RESET;
         r_nxt.scale = core_rail_pkg::SCALE_RESET;
         r_nxt.fet = core_rail_pkg::FET_RESET;
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n)
   begin
      if (!rst_n)
         r_r <= '{ctrl: core_rail_pkg::CTRL_RESET, default: '0};
      else
         r_r <= r_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   rail_slew #(
      .UNIT_CYC    (UNIT_CYC)
   ) u_slew (
      .clk_i       (MCLK_I),
      .rst_n_i     (rst_n),
      .clear_i     (TURNOFF_RESET_I),
      .target_i    (r_r.target),
      .step_time_i (r_r.ctrl[core_rail_pkg::STEP_HI:core_rail_pkg::STEP_LO]),
      .bypass_i    (SLEW_BYPASS_I),
      .level_o     (slew_level),
      .busy_o      (slew_busy)
   );

   assign CTL_RDATA_O               = r_r.ctl_rd;
   assign SCL_RDATA_O               = r_r.scl_rd;
   assign OUTPUT_GAIN_CHOICE_O      = r_r.gain;
   assign LOAD_CURRENT_LIMIT_HIGH_O = r_r.ilim;
   assign CORE_RAIL_ON_O            = r_r.on;
   assign CORE_RAIL_LOW_POWER_O     = r_r.lowp;
   assign CORE_RAIL_TARGET_O        = r_r.target;
   assign CORE_RAIL_LEVEL_O         = r_r.level;
   assign CORE_RAIL_SLEWING_O       = r_r.slewing;
   assign EXTERNAL_FET_RAIL_ON_O    = r_r.fet_on;
endmodule

// *** src/core_rail_pkg.sv ***
// Constants for the second core rail and external-FET rail register bank.
// Assumes byte-wide register access from two access ports selected by one bit.
package core_rail_pkg;
   localparam logic [7:0] CTRL_OFFSET      = 8'h24;
   localparam logic [7:0] OPER_OFFSET      = 8'h25;
   localparam logic [7:0] SCALE_OFFSET     = 8'h26;
   localparam logic [7:0] FET_OFFSET       = 8'h27;
   localparam logic [7:0] CTRL_RESET       = 8'h04;
   localparam logic [7:0] OPER_RESET       = 8'h00;
   localparam logic [7:0] SCALE_RESET      = 8'h00;
   localparam logic [7:0] FET_RESET        = 8'h00;
   localparam logic [7:0] SCALE_WMASK      = 8'h7f;
   localparam logic [7:0] FET_WMASK        = 8'h03;
   localparam int         GAIN_HI          = 7;
   localparam int         GAIN_LO          = 6;
   localparam int         ILIM_BIT         = 5;
   localparam int         STEP_HI          = 4;
   localparam int         STEP_LO          = 2;
   localparam int         STATE_HI         = 1;
   localparam int         STATE_LO         = 0;
   localparam int         CMD_BIT          = 7;
   localparam logic [6:0] CODE_OFF         = 7'h00;
   localparam logic [6:0] CODE_MIN         = 7'h03;
   localparam logic [6:0] CODE_MAX         = 7'h4b;
   // Target in 12.5 mV units: code + 45 (0.5625 V / 12.5 mV)
   localparam logic [9:0] BASE_STEPS       = 10'h02d;
   // Slew pacing: cycles per 12.5 mV step = (slew_step_time + 1) * STEP_UNIT_CYC
   localparam int         STEP_UNIT_NS     = 1000;
   localparam int         CLK_PERIOD_NS    = 5;
   localparam int         STEP_UNIT_CYC    = STEP_UNIT_NS / CLK_PERIOD_NS;
endpackage

// *** src/rail_slew.sv ***
// Moves the applied rail level toward its target in single 12.5 mV units.
// Assumes target and pacing come from registers in the same clock domain.
`timescale 1ns/1ps
module rail_slew #(
   parameter int UNIT_CYC = core_rail_pkg::STEP_UNIT_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       clear_i,
   input  wire logic [9:0] target_i,
   input  wire logic [2:0] step_time_i,
   input  wire logic       bypass_i,
   output logic      [9:0] level_o,
   output logic            busy_o
);
   typedef struct packed {
      logic [9:0]  level;
      logic [15:0] cnt;
   } slew_t;
   slew_t s_r;
   slew_t s_nxt;
   logic [15:0] period;

   always_comb
   begin
      period = 16'((32'(step_time_i) + 32'd1) * UNIT_CYC);
      s_nxt = s_r;
      if (clear_i)
      begin
         s_nxt = '0;
      end
      else if (bypass_i)
      begin
         s_nxt.level = target_i;
         s_nxt.cnt = '0;
      end
      else if (s_r.level == target_i)
      begin
         s_nxt.cnt = '0;
      end
      else if (s_r.cnt + 16'h0001 >= period)
      begin
         s_nxt.cnt = '0;
         // One 12.5 mV step per period
         s_nxt.level = (s_r.level < target_i) ? s_r.level + 10'h001 : s_r.level - 10'h001;
      end
      else
      begin
         s_nxt.cnt = s_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign level_o = s_r.level;
   assign busy_o  = (s_r.level != target_i);
endmodule

// *** verification/core_rail_props.sv ***
// Port checks for the rail register bank, bound beside it.
// Assumes a host that leaves two idle edges after each read strobe.
`timescale 1ns/1ps
module core_rail_props #(
   parameter int UNIT_CYC = core_rail_pkg::STEP_UNIT_CYC
) (
   input wire logic       MCLK_I,
   input wire logic       RESET_N_I,
   input wire logic       TURNOFF_RESET_I,
   input wire logic       SCALING_PORT_CHOICE_I,
   input wire logic       SLEW_BYPASS_I,
   input wire logic [7:0] CTL_ADDR_I,
   input wire logic       CTL_RD_I,
   input wire logic [7:0] CTL_RDATA_O,
   input wire logic [1:0] OUTPUT_GAIN_CHOICE_O,
   input wire logic       CORE_RAIL_ON_O,
   input wire logic [9:0] CORE_RAIL_TARGET_O,
   input wire logic [9:0] CORE_RAIL_LEVEL_O,
   input wire logic       EXTERNAL_FET_RAIL_ON_O
);
   wire logic [9:0] t = CORE_RAIL_TARGET_O;
   wire logic [9:0] v = CORE_RAIL_LEVEL_O;
   wire logic [1:0] g = OUTPUT_GAIN_CHOICE_O;
   // Bypass or turn-off may move the level by more than one unit
   wire logic       b = SLEW_BYPASS_I | TURNOFF_RESET_I;
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);
   property p_grid;
      $stable(g) && $stable(t) && g != 2'h0 && t != 10'h000 |->
         t % g == 10'h000 && t / g inside {[48:120]};
   endproperty
   a_grid: assert property (p_grid) else $error("target off grid");
   property p_off; (t == 10'h000) [*3] |-> !CORE_RAIL_ON_O; endproperty
   a_off: assert property (p_off) else $error("rail on at code 0");
   property p_step;
      !$past(b) && !$past(b, 2) |-> v == $past(v) || v == $past(v) + 10'h001 || v + 10'h001 == $past(v);
   endproperty
   a_step: assert property (p_step) else $error("level jumped");
   property p_pace; UNIT_CYC > 1 && $changed(v) && !b && !$past(b) |=> $stable(v); endproperty
   a_pace: assert property (p_pace) else $error("steps too close");
   property p_toff;
      TURNOFF_RESET_I |-> ##2 !EXTERNAL_FET_RAIL_ON_O && !CORE_RAIL_ON_O && t == 10'h000;
   endproperty
   a_toff: assert property (p_toff) else $error("turn-off kept state");
   property p_rsv; CTL_RD_I && CTL_ADDR_I == 8'h27 |-> ##2 CTL_RDATA_O[7:2] == 6'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_refuse;
      CTL_RD_I && SCALING_PORT_CHOICE_I && CTL_ADDR_I inside {8'h25, 8'h26} |-> ##2 CTL_RDATA_O == 8'h00;
   endproperty
   a_refuse: assert property (p_refuse) else $error("foreign read served");
   property p_hold; !CTL_RD_I && !$past(CTL_RD_I) && !TURNOFF_RESET_I |=> $stable(CTL_RDATA_O); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   c_slew: cover property ($changed(v) && !b);
   c_refuse: cover property (CTL_RD_I && SCALING_PORT_CHOICE_I);
   c_toff: cover property (TURNOFF_RESET_I);
endmodule

// *** verification/rail_host_model.sv ***
// Host on both register ports: one byte write or read per call.
// Assumes port 0 is control and port 1 is voltage scaling.
`timescale 1ns/1ps
module rail_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i [2],
   output logic      [7:0] addr_o  [2],
   output logic      [7:0] wdata_o [2],
   output logic            wr_o    [2],
   output logic            rd_o    [2]
);
   initial
   begin
      addr_o = '{default: 8'h00};
      wdata_o = '{default: 8'h00};
      wr_o = '{default: 1'b0};
      rd_o = '{default: 1'b0};
   end
   // Released lines show the inverse so stale values never look valid
   task automatic access(input int p, input logic w, input logic [7:0] a, dt,
                         output logic [7:0] q);
      @(negedge clk_i);
      addr_o[p] = a;
      wdata_o[p] = dt;
      wr_o[p] = w;
      rd_o[p] = !w;
      @(negedge clk_i);
      wr_o[p] = 1'b0;
      rd_o[p] = 1'b0;
      addr_o[p] = ~a;
      wdata_o[p] = ~dt;
      @(negedge clk_i);
      q = rdata_i[p];
   endtask
endmodule

// *** verification/test_core_rail_and_fet_ctrl_regs.sv ***
// Self-checking bench for the rail register bank with a host on both ports.
// Assumes UNIT_CYC cut to 2 so every slew ends within a few hundred cycles.
`timescale 1ns/1ps
module test_core_rail_and_fet_ctrl_regs;
   logic       MCLK_I = 1'b0;
   logic       RESET_N_I = 1'b0;
   logic       TURNOFF_RESET_I = 1'b0;
   logic       SCALING_PORT_CHOICE_I = 1'b0;
   logic       SLEW_BYPASS_I = 1'b1;
   logic [7:0] a [2], d [2], q [2], rb, cv, ov, sv, fv;
   logic       w [2], r [2], LOAD_CURRENT_LIMIT_HIGH_O, CORE_RAIL_ON_O, CORE_RAIL_LOW_POWER_O;
   logic       CORE_RAIL_SLEWING_O, EXTERNAL_FET_RAIL_ON_O;
   logic [1:0] OUTPUT_GAIN_CHOICE_O;
   logic [9:0] CORE_RAIL_TARGET_O, CORE_RAIL_LEVEL_O, e;
   logic [6:0] corner [6] = '{7'h00, 7'h01, 7'h03, 7'h4b, 7'h4c, 7'h7f};
   int         error_cnt = 0, check_count = 0, seed = 41, n, p;
   always #2.5 MCLK_I = ~MCLK_I;
   core_rail_and_fet_ctrl_regs #(.UNIT_CYC(2)) i_core_rail_and_fet_ctrl_regs (
      .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .TURNOFF_RESET_I(TURNOFF_RESET_I),
      .SCALING_PORT_CHOICE_I(SCALING_PORT_CHOICE_I), .SLEW_BYPASS_I(SLEW_BYPASS_I),
      .CTL_ADDR_I(a[0]), .CTL_WDATA_I(d[0]), .CTL_WR_I(w[0]), .CTL_RD_I(r[0]),
      .CTL_RDATA_O(q[0]), .SCL_ADDR_I(a[1]), .SCL_WDATA_I(d[1]), .SCL_WR_I(w[1]),
      .SCL_RD_I(r[1]), .SCL_RDATA_O(q[1]),
      .OUTPUT_GAIN_CHOICE_O(OUTPUT_GAIN_CHOICE_O),
      .LOAD_CURRENT_LIMIT_HIGH_O(LOAD_CURRENT_LIMIT_HIGH_O),
      .CORE_RAIL_ON_O(CORE_RAIL_ON_O), .CORE_RAIL_LOW_POWER_O(CORE_RAIL_LOW_POWER_O),
      .CORE_RAIL_TARGET_O(CORE_RAIL_TARGET_O), .CORE_RAIL_LEVEL_O(CORE_RAIL_LEVEL_O),
      .CORE_RAIL_SLEWING_O(CORE_RAIL_SLEWING_O),
      .EXTERNAL_FET_RAIL_ON_O(EXTERNAL_FET_RAIL_ON_O));
   rail_host_model i_rail_host_model (.clk_i(MCLK_I), .rdata_i(q), .addr_o(a), .wdata_o(d),
      .wr_o(w), .rd_o(r));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] tgt(input logic [6:0] c, input logic [1:0] g);
      logic [6:0] k;
      k = (c < 7'h03) ? 7'h03 : ((c > 7'h4b) ? 7'h4b : c);
      return (c == 7'h00) ? 10'h000 : ({3'h0, k} + 10'h02d) * ((g < 2'h2) ? 10'h001 : {8'h00, g});
   endfunction
   task automatic chk(input logic [9:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input int pt, input logic wr, input logic [7:0] ad, dt);
      i_rail_host_model.access(pt, wr, ad, dt, rb);
   endtask
   task automatic rdc(input int pt, input logic [7:0] ad, exp);
      acc(pt, 1'b0, ad, 8'h00);
      chk({2'h0, rb}, {2'h0, exp});
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(negedge MCLK_I);
      RESET_N_I = 1'b1;
      repeat (3) @(negedge MCLK_I);
      rdc(0, 8'h24, 8'h04);
      rdc(0, 8'h25, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         p = i % 2;
         {cv, ov, sv, fv} = $random(seed);
         if (i < 6)
            ov = {1'b0, corner[i]};
         SCALING_PORT_CHOICE_I = p[0];
         acc(0, 1'b1, 8'h24, cv);
         acc(p, 1'b1, 8'h25, ov);
         acc(p, 1'b1, 8'h26, sv);
         acc(0, 1'b1, 8'h27, fv);
         acc(1 - p, 1'b1, 8'h25, ~ov);
         rdc(0, 8'h24, cv);
         rdc(p, 8'h25, ov);
         rdc(p, 8'h26, sv & 8'h7f);
         rdc(1 - p, 8'h26, 8'h00);
         rdc(0, 8'h27, fv & 8'h03);
         e = tgt(ov[7] ? sv[6:0] : ov[6:0], cv[7:6]);
         chk(CORE_RAIL_TARGET_O, e);
         chk(CORE_RAIL_LEVEL_O, e);
         chk({8'h00, OUTPUT_GAIN_CHOICE_O}, {8'h00, (cv[7:6] < 2'h2) ? 2'h1 : cv[7:6]});
         chk({9'h000, LOAD_CURRENT_LIMIT_HIGH_O}, {9'h000, cv[5]});
         chk({8'h00, CORE_RAIL_ON_O, CORE_RAIL_LOW_POWER_O}, {8'h00, cv[0] && e != 0, &cv[1:0]});
         chk({9'h000, EXTERNAL_FET_RAIL_ON_O}, {9'h000, fv[0]});
      end
      // Setpoints belong to the control port again for the slew timing runs
      SCALING_PORT_CHOICE_I = 1'b0;
      acc(0, 1'b1, 8'h24, 8'h05);
      acc(0, 1'b1, 8'h25, 8'h03);
      // Let the bypassed level settle on the start value before slewing is timed
      repeat (2) @(negedge MCLK_I);
      SLEW_BYPASS_I = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         acc(0, 1'b1, 8'h24, {3'h0, k[2:0], 2'h1});
         acc(0, 1'b1, 8'h25, k[0] ? 8'h03 : 8'h0d);
         @(negedge MCLK_I);
         chk({9'h000, CORE_RAIL_SLEWING_O}, 10'h001);
         for (n = 0; CORE_RAIL_SLEWING_O !== 1'b0 && n < 2000; n++)
            @(negedge MCLK_I);
         if (n == 2000)
         begin
            error_cnt++;
            break;
         end
         chk({9'h000, n inside {[(k + 1) * 20 - 6 : (k + 1) * 20 + 6]}}, 10'h001);
         chk(CORE_RAIL_LEVEL_O, k[0] ? 10'h030 : 10'h03a);
      end
      acc(0, 1'b1, 8'h27, 8'h01);
      chk({9'h000, EXTERNAL_FET_RAIL_ON_O}, 10'h001);
      TURNOFF_RESET_I = 1'b1;
      @(negedge MCLK_I) TURNOFF_RESET_I = 1'b0;
      rdc(0, 8'h24, 8'h04);
      rdc(0, 8'h27, 8'h00);
      chk(CORE_RAIL_TARGET_O, 10'h000);
      chk(CORE_RAIL_LEVEL_O, 10'h000);
      chk({9'h000, EXTERNAL_FET_RAIL_ON_O}, 10'h000);
      print_verdict();
   end
endmodule
bind core_rail_and_fet_ctrl_regs core_rail_props #(
   .UNIT_CYC               (UNIT_CYC)
) i_core_rail_props (
   .MCLK_I                 (MCLK_I),
   .RESET_N_I              (RESET_N_I),
   .TURNOFF_RESET_I        (TURNOFF_RESET_I),
   .SCALING_PORT_CHOICE_I  (SCALING_PORT_CHOICE_I),
   .SLEW_BYPASS_I          (SLEW_BYPASS_I),
   .CTL_ADDR_I             (CTL_ADDR_I),
   .CTL_RD_I               (CTL_RD_I),
   .CTL_RDATA_O            (CTL_RDATA_O),
   .OUTPUT_GAIN_CHOICE_O   (OUTPUT_GAIN_CHOICE_O),
   .CORE_RAIL_ON_O         (CORE_RAIL_ON_O),
   .CORE_RAIL_TARGET_O     (CORE_RAIL_TARGET_O),
   .CORE_RAIL_LEVEL_O      (CORE_RAIL_LEVEL_O),
   .EXTERNAL_FET_RAIL_ON_O (EXTERNAL_FET_RAIL_ON_O)
);
